/* File: design/fes_pkg.sv */
/*
 * Constants for the flash erase host sequencer: command codes, unlock
 * addresses, status bit positions, strobe timing and state encoding.
 * Assumes a 10 MHz system clock and a word-mode parallel flash.
 */
package fes_pkg;
	localparam int            CLK_MHZ        = 10;
	localparam int            ADDR_W         = 21;
	localparam int            DATA_W         = 16;
	localparam logic [20:0]   UNLOCK_ADDR_1  = 21'h000555;
	localparam logic [20:0]   UNLOCK_ADDR_2  = 21'h0002aa;
	localparam logic [15:0]   CMD_UNLOCK_1   = 16'h00aa;
	localparam logic [15:0]   CMD_UNLOCK_2   = 16'h0055;
	localparam logic [15:0]   CMD_SETUP      = 16'h0080;
	localparam logic [15:0]   CMD_CHIP_ERASE = 16'h0010;
	localparam logic [15:0]   CMD_SECT_ERASE = 16'h0030;
	localparam logic [15:0]   CMD_SUSPEND    = 16'h00b0;
	localparam logic [15:0]   CMD_RESUME     = 16'h0030;
	localparam logic [15:0]   CMD_RESET      = 16'h00f0;
	localparam int            SECT_HI        = 20;
	localparam int            SECT_LO        = 12;
	localparam int            DATA_POLL_POS  = 7;
	localparam int            TOGGLE_POS     = 6;
	localparam int            TIMEOUT_POS    = 5;
	localparam int            ERASE_TMR_POS  = 3;
	localparam int            ERASE_TGL_POS  = 2;
	// Strobe phase lengths, least times in ns, rounded up to cycles
	localparam int            T_STROBE_NS    = 100;
	localparam int            T_SETTLE_NS    = 100;
	localparam int            STROBE_CYC     = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int            SETTLE_CYC     = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int            T_SUSPEND_US   = 20;
	localparam int            SUSPEND_CYC    = T_SUSPEND_US * CLK_MHZ;
	localparam logic [7:0]    STROBE_CNT     = 8'(STROBE_CYC);
	localparam logic [7:0]    SETTLE_CNT     = 8'(SETTLE_CYC);
	localparam logic [11:0]   SUSPEND_CNT    = 12'(SUSPEND_CYC);
	localparam logic [2:0]    SEQ_LEN        = 3'h6;

	typedef enum logic [2:0] {
		FES_IDLE    = 3'b000,
		FES_SETUP   = 3'b001,
		FES_STROBE  = 3'b010,
		FES_SETTLE  = 3'b011,
		FES_WAIT    = 3'b100
	} fes_state_t;

	typedef enum logic [2:0] {
		FES_OP_CHIP    = 3'h0,
		FES_OP_SECTOR  = 3'h1,
		FES_OP_SUSPEND = 3'h2,
		FES_OP_RESUME  = 3'h3,
		FES_OP_RESET   = 3'h4,
		FES_OP_READ    = 3'h5
	} fes_op_t;
endpackage : fes_pkg

/* File: design/fes_host.sv */
/*
 * Host-side erase sequencer for an asynchronous parallel NOR flash.
 * Issues chip/sector erase sequences, suspend, resume, reset and status
 * reads over the strobe pins, and tracks erase state by toggle polling.
 * Assumes the flash pins are wired directly; ready_busy_n is pulled up
 * externally and arrives asynchronously, as does read data.
 */
// Summary of operation
// - Chip erase: two unlocks, setup, two unlocks, chip erase command.
// - Sector erase: six writes, the last carries sector address and command.
// - One sector per erase; next only after previous completes.
// - Resume leaves suspend; repeated resumes are not sent.
// - Status polls use sect_q, the sector of the last erase or read command.
// - Final data is taken from a read after completion is seen.
// - Timeout bit with toggle still running flags failure, then reset.
`timescale 1ns/1ps
module fes_host
	import fes_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	input  wire logic                    cmd_valid,
	input  wire fes_pkg::fes_op_t        cmd_op,
	input  wire logic [8:0]              cmd_sector,
	output logic                         cmd_ready,
	output logic                         done_pulse,
	output logic                         fail_pulse,
	output logic [15:0]                  read_data_q,
	output logic                         erasing_q,
	output logic                         suspended_q,
	output logic                         flash_busy,
	output logic [20:0]                  flash_addr_q,
	output logic [15:0]                  flash_dq_out_q,
	output logic                         flash_dq_oe_q,
	input  wire logic [15:0]             flash_dq_in,
	output logic                         flash_ce_n_q,
	output logic                         flash_we_n_q,
	output logic                         flash_oe_n_q,
	input  wire logic                    ready_busy_n
);
	import fes_pkg::*;

	fes_state_t          state_q, state_d;
	logic [2:0]          step_q, step_d;
	logic [15:0]         rd_word_q, rd_word_d;
	logic [7:0]          cnt_q, cnt_d;
	logic [11:0]         susp_cnt_q, susp_cnt_d;
	logic                is_read_q, is_read_d;
	logic                poll_q, poll_d;
	logic                have_prev_q, have_prev_d;
	logic                prev_tgl_q, prev_tgl_d;
	logic                to_seen_q, to_seen_d;
	logic [2:0]          op_q, op_d;
	logic [8:0]          sect_q, sect_d;
	logic                erasing_d, suspended_d;
	logic [15:0]         read_data_d;
	logic [20:0]         addr_d;
	logic [15:0]         dout_d;
	logic                oe_dq_d, ce_d, we_d, oe_d;
	logic                done_d, fail_d;
	logic                done_q, fail_q;
	logic [15:0]         dq_s1_q, dq_s2_q;
	logic                rb_s1_q, rb_s2_q;
	logic [20:0]         w_addr;
	logic [15:0]         w_data;
	logic                accept;
	logic                op_legal;

	// Async pins pass two flops before use
	always_ff @(posedge sys_clk) begin
		dq_s1_q <= flash_dq_in;
		dq_s2_q <= dq_s1_q;
		rb_s1_q <= ready_busy_n;
		rb_s2_q <= rb_s1_q;
	end

	assign flash_busy = ~rb_s2_q;
	assign done_pulse = done_q;
	assign fail_pulse = fail_q;

	// Write cycle address/data for each step of the selected operation
	always_comb begin
		w_addr = UNLOCK_ADDR_1;
		w_data = CMD_RESET;
		unique case (step_q)
			3'h0, 3'h3: begin
				w_addr = UNLOCK_ADDR_1;
				w_data = CMD_UNLOCK_1;
			end
			3'h1, 3'h4: begin
				w_addr = UNLOCK_ADDR_2;
				w_data = CMD_UNLOCK_2;
			end
			3'h2: begin
				w_addr = UNLOCK_ADDR_1;
				w_data = CMD_SETUP;
			end
			default: begin
				if (op_q == FES_OP_SECTOR) begin
					w_addr = {sect_q, 12'h000};
					w_data = CMD_SECT_ERASE;
				end else begin
					w_addr = UNLOCK_ADDR_1;
					w_data = CMD_CHIP_ERASE;
				end
			end
		endcase
		if (op_q == FES_OP_SUSPEND) begin
			w_data = CMD_SUSPEND;
		end else if (op_q == FES_OP_RESUME) begin
			w_data = CMD_RESUME;
		end else if (op_q == FES_OP_RESET) begin
			w_data = CMD_RESET;
		end
	end

	// Which commands are legal in the present erase state
	always_comb begin
		op_legal = 1'b0;
		unique case (cmd_op)
			FES_OP_CHIP, FES_OP_SECTOR: op_legal = ~erasing_q;
			FES_OP_SUSPEND: op_legal = erasing_q & ~suspended_q & (op_q == FES_OP_SECTOR);
			FES_OP_RESUME:  op_legal = suspended_q;
			FES_OP_RESET:   op_legal = ~erasing_q | to_seen_q;
			FES_OP_READ:    op_legal = 1'b1;
			default:        op_legal = 1'b0;
		endcase
	end

	// Suspend has to break into erase polling, everything else waits for it
	assign cmd_ready = (state_q == FES_IDLE) & op_legal &
		(~poll_q | (cmd_op == FES_OP_SUSPEND));
	assign accept    = cmd_valid & cmd_ready;

	always_comb begin
		state_d     = state_q;
		step_d      = step_q;
		rd_word_d   = rd_word_q;
		cnt_d       = cnt_q;
		susp_cnt_d  = susp_cnt_q;
		is_read_d   = is_read_q;
		poll_d      = poll_q;
		have_prev_d = have_prev_q;
		prev_tgl_d  = prev_tgl_q;
		to_seen_d   = to_seen_q;
		op_d        = op_q;
		sect_d      = sect_q;
		erasing_d   = erasing_q;
		suspended_d = suspended_q;
		read_data_d = read_data_q;
		addr_d      = flash_addr_q;
		dout_d      = flash_dq_out_q;
		oe_dq_d     = flash_dq_oe_q;
		ce_d        = flash_ce_n_q;
		we_d        = flash_we_n_q;
		oe_d        = flash_oe_n_q;
		done_d      = 1'b0;
		fail_d      = 1'b0;
		unique case (state_q)
			FES_IDLE: begin
				if (accept) begin
					is_read_d = (cmd_op == FES_OP_READ);
					if (cmd_op != FES_OP_READ) begin
						op_d = 3'(cmd_op);
					end
					if (cmd_op == FES_OP_CHIP || cmd_op == FES_OP_SECTOR) begin
						sect_d = (cmd_op == FES_OP_SECTOR) ? cmd_sector : 9'h000;
						step_d = 3'h0;
					end else begin
						step_d = 3'h5;
					end
					if (cmd_op == FES_OP_READ) begin
						sect_d = cmd_sector;
					end
					state_d = FES_SETUP;
				end else if (poll_q) begin
					// Polling re-reads sector sect_q, last set by an erase or read command
					is_read_d = 1'b1;
					state_d   = FES_SETUP;
				end
			end
			FES_SETUP: begin
				ce_d  = 1'b0;
				cnt_d = STROBE_CNT;
				if (is_read_q) begin
					addr_d  = {sect_q, 12'h000};
					oe_dq_d = 1'b0;
					oe_d    = 1'b0;
				end else begin
					addr_d  = w_addr;
					dout_d  = w_data;
					oe_dq_d = 1'b1;
					we_d    = 1'b0;
				end
				state_d = FES_STROBE;
			end
			FES_STROBE: begin
				if (cnt_q > 8'h01) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					ce_d    = 1'b1;
					we_d    = 1'b1;
					oe_d    = 1'b1;
					oe_dq_d = 1'b0;
					cnt_d   = SETTLE_CNT + 8'h02;
					state_d = FES_SETTLE;
				end
			end
			FES_SETTLE: begin
				// Synchroniser latency is covered by the extra settle cycles
				if (cnt_q > 8'h01) begin
					cnt_d = cnt_q - 8'h01;
					// Bus is released by now; only this synced copy saw the strobe
					if (cnt_q == SETTLE_CNT + 8'h01) begin
						rd_word_d = dq_s2_q;
					end
				end else if (is_read_q) begin
					is_read_d = 1'b0;
					state_d   = FES_IDLE;
					if (!poll_q) begin
						read_data_d = rd_word_q;
						done_d      = 1'b1;
					end else begin
						// Toggle compare on successive reads
						have_prev_d = 1'b1;
						prev_tgl_d  = rd_word_q[TOGGLE_POS];
						to_seen_d   = to_seen_q | rd_word_q[TIMEOUT_POS];
						if (have_prev_q && prev_tgl_q == rd_word_q[TOGGLE_POS]) begin
							// Stopped toggling: done, incl. protected sectors
							poll_d      = 1'b0;
							erasing_d   = 1'b0;
							have_prev_d = 1'b0;
							to_seen_d   = 1'b0;
							done_d      = 1'b1;
						end else if (have_prev_q && to_seen_q) begin
							// Still toggling after timeout: fail, host resets
							poll_d      = 1'b0;
							have_prev_d = 1'b0;
							fail_d      = 1'b1;
						end
					end
				end else if (step_q + 3'h1 < SEQ_LEN) begin
					step_d  = step_q + 3'h1;
					state_d = FES_SETUP;
				end else begin
					state_d = FES_IDLE;
					unique case (op_q)
						3'(FES_OP_CHIP), 3'(FES_OP_SECTOR): begin
							erasing_d   = 1'b1;
							poll_d      = 1'b1;
							have_prev_d = 1'b0;
							to_seen_d   = 1'b0;
						end
						3'(FES_OP_SUSPEND): begin
							susp_cnt_d = SUSPEND_CNT;
							state_d    = FES_WAIT;
						end
						3'(FES_OP_RESUME): begin
							suspended_d = 1'b0;
							op_d        = 3'(FES_OP_SECTOR);
							poll_d      = 1'b1;
							have_prev_d = 1'b0;
							done_d      = 1'b1;
						end
						default: begin
							erasing_d   = 1'b0;
							suspended_d = 1'b0;
							to_seen_d   = 1'b0;
							done_d      = 1'b1;
						end
					endcase
				end
			end
			FES_WAIT: begin
				if (susp_cnt_q > 12'h001) begin
					susp_cnt_d = susp_cnt_q - 12'h001;
				end else begin
					suspended_d = 1'b1;
					poll_d      = 1'b0;
					op_d        = 3'(FES_OP_SECTOR);
					done_d      = 1'b1;
					state_d     = FES_IDLE;
				end
			end
			default: state_d = FES_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q        <= FES_IDLE;
			step_q         <= 3'h0;
			rd_word_q      <= 16'h0000;
			cnt_q          <= 8'h00;
			susp_cnt_q     <= 12'h000;
			is_read_q      <= 1'b0;
			poll_q         <= 1'b0;
			have_prev_q    <= 1'b0;
			prev_tgl_q     <= 1'b0;
			to_seen_q      <= 1'b0;
			op_q           <= 3'h0;
			sect_q         <= 9'h000;
			erasing_q      <= 1'b0;
			suspended_q    <= 1'b0;
			read_data_q    <= 16'h0000;
			flash_addr_q   <= 21'h000000;
			flash_dq_out_q <= 16'h0000;
			flash_dq_oe_q  <= 1'b0;
			flash_ce_n_q   <= 1'b1;
			flash_we_n_q   <= 1'b1;
			flash_oe_n_q   <= 1'b1;
			done_q         <= 1'b0;
			fail_q         <= 1'b0;
		end else begin
			state_q        <= state_d;
			step_q         <= step_d;
			rd_word_q      <= rd_word_d;
			cnt_q          <= cnt_d;
			susp_cnt_q     <= susp_cnt_d;
			is_read_q      <= is_read_d;
			poll_q         <= poll_d;
			have_prev_q    <= have_prev_d;
			prev_tgl_q     <= prev_tgl_d;
			to_seen_q      <= to_seen_d;
			op_q           <= op_d;
			sect_q         <= sect_d;
			erasing_q      <= erasing_d;
			suspended_q    <= suspended_d;
			read_data_q    <= read_data_d;
			flash_addr_q   <= addr_d;
			flash_dq_out_q <= dout_d;
			flash_dq_oe_q  <= oe_dq_d;
			flash_ce_n_q   <= ce_d;
			flash_we_n_q   <= we_d;
			flash_oe_n_q   <= oe_d;
			done_q         <= done_d;
			fail_q         <= fail_d;
		end
	end
endmodule : fes_host

/* File: tb/fes_host_monitor.sv */
/* Checker for fes_host: strobe shape, command gating, answer times.
   Bound into fes_host below; sees its ports only. */
`timescale 1ns/1ps
module fes_host_monitor
	import fes_pkg::*;
(
	input wire logic		sys_clk,
	input wire logic		reset,
	input wire logic		cmd_valid,
	input wire fes_pkg::fes_op_t	cmd_op,
	input wire logic		cmd_ready,
	input wire logic		done_pulse,
	input wire logic		fail_pulse,
	input wire logic		erasing_q,
	input wire logic		suspended_q,
	input wire logic		flash_busy,
	input wire logic		flash_dq_oe_q,
	input wire logic		flash_ce_n_q,
	input wire logic		flash_we_n_q,
	input wire logic		flash_oe_n_q,
	input wire logic		ready_busy_n
);
	import fes_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire logic take = cmd_valid && cmd_ready;

	property p_write_pins; !flash_we_n_q |-> !flash_ce_n_q && flash_oe_n_q && flash_dq_oe_q;
	endproperty
	a_write_pins: assert property (p_write_pins) else $error("bad write pins");
	property p_we_gap; $fell(flash_we_n_q) |=> flash_we_n_q [*3]; endproperty
	a_we_gap: assert property (p_we_gap) else $error("write strobe too long");
	property p_sus_legal; take && cmd_op == FES_OP_SUSPEND |-> erasing_q && !suspended_q;
	endproperty
	a_sus_legal: assert property (p_sus_legal) else $error("suspend taken");
	property p_one_sector; cmd_valid && erasing_q && (cmd_op == FES_OP_SECTOR ||
		cmd_op == FES_OP_CHIP) |-> !cmd_ready; endproperty
	a_one_sector: assert property (p_one_sector) else $error("erase overlap");
	property p_res_legal; cmd_valid && !suspended_q && cmd_op == FES_OP_RESUME |-> !cmd_ready;
	endproperty
	a_res_legal: assert property (p_res_legal) else $error("resume taken");
	property p_sus_time; take && cmd_op == FES_OP_SUSPEND |-> ##[200:210] done_pulse; endproperty
	a_sus_time: assert property (p_sus_time) else $error("suspend time");
	property p_rd_time; take && cmd_op == FES_OP_READ |-> ##[5:7] done_pulse; endproperty
	a_rd_time: assert property (p_rd_time) else $error("read time");
	property p_busy; !ready_busy_n [*3] |-> flash_busy; endproperty
	a_busy: assert property (p_busy) else $error("busy not seen");
	c_sus: cover property (take && cmd_op == FES_OP_SUSPEND);
	c_fail: cover property (fail_pulse);
	c_done: cover property ($fell(erasing_q));
endmodule : fes_host_monitor

bind fes_host fes_host_monitor u_mon (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
	.cmd_op(cmd_op), .cmd_ready(cmd_ready), .done_pulse(done_pulse), .fail_pulse(fail_pulse),
	.erasing_q(erasing_q), .suspended_q(suspended_q), .flash_busy(flash_busy),
	.flash_dq_oe_q(flash_dq_oe_q), .flash_ce_n_q(flash_ce_n_q), .flash_we_n_q(flash_we_n_q),
	.flash_oe_n_q(flash_oe_n_q), .ready_busy_n(ready_busy_n));

/* File: tb/fes_flash_model.sv */
/* Behavioural flash device: erase sequence decode, suspend, resume,
   reset and status reads. Assumes host pins wired straight; erase
   length counted in status reads, not time. */
`timescale 1ns/1ps
module fes_flash_model
	import fes_pkg::*;
#(
	parameter int POLLS = 20
) (
	input wire logic [20:0]	addr,
	input wire logic [15:0]	dq_wr,
	input wire logic	dq_oe,
	input wire logic	ce_n,
	input wire logic	we_n,
	input wire logic	oe_n,
	input wire logic	fail_en,
	output logic [15:0]	dq_rd,
	output logic		rb_oe
);
	import fes_pkg::*;
	localparam logic [36:0] SEQ [5] = '{{UNLOCK_ADDR_1, CMD_UNLOCK_1},
		{UNLOCK_ADDR_2, CMD_UNLOCK_2}, {UNLOCK_ADDR_1, CMD_SETUP},
		{UNLOCK_ADDR_1, CMD_UNLOCK_1}, {UNLOCK_ADDR_2, CMD_UNLOCK_2}};
	logic [511:0]	blank_q = '0;
	logic [8:0]	sect_q = '0;
	logic [15:0]	last_q = '0;
	logic [15:0]	rd_val;
	logic [15:0]	wd = '0;
	logic [20:0]	wa = '0;
	logic		busy_q = 0, susp_q = 0, sop_q = 0, tmo_q = 0, tog_q = 0, tog2_q = 0, sel = 0;
	int		step_q = 0, polls_q = 0;

	always_comb begin
		if (busy_q && !susp_q)
			rd_val = {8'h00, 1'b0, tog_q, tmo_q, 1'b0, sop_q, tog2_q, 2'b00};
		else if (busy_q && addr[20:12] == sect_q)
			rd_val = {8'h00, 1'b1, tog_q, 3'b000, tog2_q, 2'b00};
		else
			rd_val = blank_q[addr[20:12]] ? 16'hffff : {7'h00, addr[20:12]};
	end
	// Released bus shows the inverse, never a stale value
	assign dq_rd = (!ce_n && !oe_n && !dq_oe) ? rd_val : ~last_q;
	assign rb_oe = busy_q && !susp_q;

	always @(negedge we_n, negedge oe_n) begin
		#1 sel = !ce_n;
		wa = addr;
		wd = dq_wr;
		if (!oe_n) last_q = rd_val;
	end
	always @(posedge oe_n) if (sel && busy_q) begin
		if (!susp_q) begin
			tog_q = !tog_q;
			polls_q++;
			if (fail_en) tmo_q = 1'b1;
			else if (polls_q >= POLLS) begin
				busy_q = 1'b0;
				if (sop_q) blank_q[sect_q] = 1'b1;
				else blank_q = '1;
			end
		end
		if (!sop_q || wa[20:12] == sect_q) tog2_q = !tog2_q;
	end
	always @(posedge we_n) if (sel) begin
		if (busy_q) begin
			if (sop_q && !susp_q && wd[7:0] == CMD_SUSPEND[7:0]) susp_q = 1'b1;
			else if (susp_q && wd[7:0] == CMD_RESUME[7:0]) susp_q = 1'b0;
			else if (tmo_q && wd[7:0] == CMD_RESET[7:0]) begin
				busy_q = 1'b0;
				tmo_q = 1'b0;
				susp_q = 1'b0;
			end
		end else if (step_q == 5 && (wd == CMD_SECT_ERASE || {wa, wd} ==
			{UNLOCK_ADDR_1, CMD_CHIP_ERASE})) begin
			busy_q = 1'b1;
			sop_q = wd == CMD_SECT_ERASE;
			sect_q = wa[20:12];
			polls_q = 0;
			step_q = 0;
		end else if (step_q < 5 && {wa, wd} == SEQ[step_q]) step_q++;
		else step_q = 0;
	end
endmodule : fes_flash_model

/* File: tb/fes_host_tb.sv */
/* Self-checking bench for fes_host with a behavioural flash beside it.
   Ready/busy line is pulled up here. */
`timescale 1ns/1ps
module fes_host_tb;
	import fes_pkg::*;
	logic		sys_clk = 0, reset = 1, cmd_valid = 0, fail_en = 0, rb_oe;
	fes_op_t	cmd_op = FES_OP_READ;
	logic [8:0]	cmd_sector = '0;
	logic		cmd_ready, done_pulse, fail_pulse, erasing_q, suspended_q, flash_busy;
	logic [15:0]	read_data_q, flash_dq_out_q, flash_dq_in;
	logic [20:0]	flash_addr_q;
	logic		flash_dq_oe_q, flash_ce_n_q, flash_we_n_q, flash_oe_n_q;
	int		bad_count = 0, comparisons = 0, cyc = 0;
	wire logic	ready_busy_n = rb_oe ? 1'b0 : 1'b1;

	fes_host dut (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_sector(cmd_sector), .cmd_ready(cmd_ready), .done_pulse(done_pulse),
		.fail_pulse(fail_pulse), .read_data_q(read_data_q), .erasing_q(erasing_q),
		.suspended_q(suspended_q), .flash_busy(flash_busy), .flash_addr_q(flash_addr_q),
		.flash_dq_out_q(flash_dq_out_q), .flash_dq_oe_q(flash_dq_oe_q),
		.flash_dq_in(flash_dq_in), .flash_ce_n_q(flash_ce_n_q), .flash_we_n_q(flash_we_n_q),
		.flash_oe_n_q(flash_oe_n_q), .ready_busy_n(ready_busy_n));
	fes_flash_model u_flash (.addr(flash_addr_q), .dq_wr(flash_dq_out_q), .dq_oe(flash_dq_oe_q),
		.ce_n(flash_ce_n_q), .we_n(flash_we_n_q), .oe_n(flash_oe_n_q), .fail_en(fail_en),
		.dq_rd(flash_dq_in), .rb_oe(rb_oe));

	initial begin
		forever #50 sys_clk = !sys_clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic take(input fes_op_t op, input logic [8:0] s);
		int n;
		n = 0;
		cmd_op <= op;
		cmd_sector <= s;
		cmd_valid <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 400);
		cmd_valid <= 1'b0;
		chk({15'h0, cmd_ready}, 16'h0001);
	endtask : take

	task automatic refuse(input fes_op_t op);
		cmd_op <= op;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		chk({15'h0, cmd_ready}, 16'h0000);
		cmd_valid <= 1'b0;
		@(posedge sys_clk);
	endtask : refuse

	// Bounded wait for the one-cycle answer; fl tells failure from success
	task automatic wait_done(output logic fl);
		int n;
		n = 0;
		fl = 1'b0;
		do begin
			@(posedge sys_clk);
			n++;
			if (fail_pulse === 1'b1) fl = 1'b1;
		end while (done_pulse !== 1'b1 && fail_pulse !== 1'b1 && n < 3000);
		chk({15'h0, n < 3000}, 16'h0001);
	endtask : wait_done

	task automatic rd(input logic [8:0] s);
		logic fl;
		take(FES_OP_READ, s);
		wait_done(fl);
	endtask : rd

	task automatic t_sector_suspend();
		logic fl;
		int n;
		take(FES_OP_SECTOR, 9'h007);
		repeat (45) @(posedge sys_clk);
		chk({14'h0, erasing_q, flash_busy}, 16'h0003);
		refuse(FES_OP_CHIP);
		take(FES_OP_SUSPEND, 9'h000);
		wait_done(fl);
		chk({14'h0, suspended_q, flash_busy}, 16'h0002);
		rd(9'h008);
		chk(read_data_q, 16'h0008);
		rd(9'h007);
		chk(read_data_q & 16'h0080, 16'h0080);
		take(FES_OP_RESUME, 9'h000);
		n = 0;
		while (erasing_q !== 1'b0 && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		chk({15'h0, erasing_q}, 16'h0000);
		refuse(FES_OP_RESUME);
		rd(9'h007);
		chk(read_data_q, 16'hffff);
	endtask : t_sector_suspend

	task automatic t_timeout();
		logic fl;
		fail_en <= 1'b1;
		take(FES_OP_SECTOR, 9'h010);
		wait_done(fl);
		chk({15'h0, fl}, 16'h0001);
		fail_en <= 1'b0;
		take(FES_OP_RESET, 9'h000);
		wait_done(fl);
		rd(9'h010);
		chk(read_data_q, 16'h0010);
	endtask : t_timeout

	task automatic t_chip();
		logic fl;
		take(FES_OP_CHIP, 9'h000);
		repeat (45) @(posedge sys_clk);
		chk({14'h0, erasing_q, flash_busy}, 16'h0003);
		refuse(FES_OP_SUSPEND);
		wait_done(fl);
		chk({15'h0, fl}, 16'h0000);
		rd(9'h1ab);
		chk(read_data_q, 16'hffff);
	endtask : t_chip

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 10000) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rd(9'h005);
		chk(read_data_q, 16'h0005);
		t_sector_suspend();
		t_timeout();
		t_chip();
		print_verdict();
	end
endmodule : fes_host_tb
